// ===== verilog/tpu_pkg.sv
// Purpose: shared constants and types of the packet user port
// Assumes: one user interface clock for both ends
// Notes: tx word layout is what the device stores in its tx fifo
package tpu_pkg;
  localparam int DATA_W = 64;
  localparam int CD_W = 12;
  localparam int CH_W = 8;
  localparam int SEL_W = 3;
  localparam int HIT_W = 7;
  localparam int BUF_W = 6;
  localparam int SYNC_W = 4;
  // credit selector codes
  localparam logic [2:0] SEL_RX_SPACE = 3'h0;
  localparam logic [2:0] SEL_RX_GRANTED = 3'h1;
  localparam logic [2:0] SEL_RX_CONSUMED = 3'h2;
  localparam logic [2:0] SEL_TX_AVAIL = 3'h4;
  localparam logic [2:0] SEL_TX_LIMIT = 3'h5;
  localparam logic [2:0] SEL_TX_CONSUMED = 3'h6;
  localparam logic [5:0] TX_BUF_MAX = 6'h20;
  // tx fifo word fields
  localparam int W_SOF = 64;
  localparam int W_EOF = 65;
  localparam int W_REM = 66;
  localparam int W_POISON = 67;
  localparam int W_ABORT = 68;
  localparam int W_STREAM = 69;
  localparam int W_DROP = 70;
  localparam int TXW_W = 71;
  // first header dword sits in the upper half of the first beat
  localparam int HDR_LEN_LSB = 32;
  localparam int HDR_4DW_BIT = 61;
  localparam int HDR_DATA_BIT = 62;
  localparam logic [10:0] HDR_LEN_ZERO = 11'h400;
  localparam logic [10:0] HDR_DW_3 = 11'h003;
  localparam logic [10:0] HDR_DW_4 = 11'h004;
  // sync vector bit positions
  localparam int S_SYS = 0;
  localparam int S_LOCK = 1;
  localparam int S_PHY = 2;
  localparam int S_LRST = 3;
  typedef enum logic [1:0] {DL_INACTIVE, DL_INIT, DL_ACTIVE} tpu_dl_type;
  typedef enum logic [1:0] {TX_IDLE, TX_USER, TX_INT} tpu_tx_type;
endpackage

// ===== verilog/tpu_if.sv
// Purpose: packet user port between device end and user end
// Assumes: all signals on the rising edge of the user interface clock
// Notes: active low handshakes end in _n
`timescale 1ns/100ps
interface tpu_if;
  import tpu_pkg::*;
  logic [CD_W-1:0] cpl_data_credits;
  logic [CH_W-1:0] cpl_hdr_credits;
  logic [CD_W-1:0] np_data_credits;
  logic [CH_W-1:0] np_hdr_credits;
  logic [CD_W-1:0] posted_data_credits;
  logic [CH_W-1:0] posted_hdr_credits;
  logic [SEL_W-1:0] credit_info_select;
  logic link_up_n;
  logic [HIT_W-1:0] rx_window_hit_n;
  logic [DATA_W-1:0] rx_beat;
  logic rx_dst_ready_n;
  logic rx_src_ready_n;
  logic rx_sof_n;
  logic rx_eof_n;
  logic rx_poisoned_n;
  logic rx_nonposted_ok_n;
  logic rx_remainder_n;
  logic rx_abort_n;
  logic [BUF_W-1:0] tx_free_buffers;
  logic tx_internal_grant_n;
  logic tx_internal_request_n;
  logic [DATA_W-1:0] tx_beat;
  logic tx_dst_ready_n;
  logic tx_src_ready_n;
  logic tx_sof_n;
  logic tx_eof_n;
  logic tx_dropped_n;
  logic tx_poison_n;
  logic tx_remainder_n;
  logic tx_abort_n;
  logic tx_streamed_n;
  logic user_if_reset_n;
  modport dev (
    output cpl_data_credits, cpl_hdr_credits, np_data_credits,
    output np_hdr_credits, posted_data_credits, posted_hdr_credits,
    output link_up_n, rx_window_hit_n, rx_beat, rx_src_ready_n,
    output rx_sof_n, rx_eof_n, rx_poisoned_n, rx_remainder_n,
    output rx_abort_n, tx_free_buffers, tx_internal_request_n,
    output tx_dst_ready_n, tx_dropped_n, user_if_reset_n,
    input credit_info_select, rx_dst_ready_n, rx_nonposted_ok_n,
    input tx_internal_grant_n, tx_beat, tx_src_ready_n, tx_sof_n,
    input tx_eof_n, tx_poison_n, tx_remainder_n, tx_abort_n,
    input tx_streamed_n
  );
  modport usr (
    input cpl_data_credits, cpl_hdr_credits, np_data_credits,
    input np_hdr_credits, posted_data_credits, posted_hdr_credits,
    input link_up_n, rx_window_hit_n, rx_beat, rx_src_ready_n,
    input rx_sof_n, rx_eof_n, rx_poisoned_n, rx_remainder_n,
    input rx_abort_n, tx_free_buffers, tx_internal_request_n,
    input tx_dst_ready_n, tx_dropped_n, user_if_reset_n,
    output credit_info_select, rx_dst_ready_n, rx_nonposted_ok_n,
    output tx_internal_grant_n, tx_beat, tx_src_ready_n, tx_sof_n,
    output tx_eof_n, tx_poison_n, tx_remainder_n, tx_abort_n,
    output tx_streamed_n
  );
endinterface

// ===== verilog/tpu_fifo.sv
// Purpose: tx word fifo with a registered output stage
// Assumes: DEPTH is a power of two
// Notes: o_level counts array entries only, not the output stage
`timescale 1ns/100ps
module tpu_fifo #(
  parameter int WIDTH = 71,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_clr,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic valid_reg;
  logic [WIDTH-1:0] data_reg;
  wire logic push = i_in_valid & o_in_ready;
  wire logic empty = (wr_reg == rd_reg);
  wire logic pop = ~empty & (~valid_reg | i_out_ready);
  assign o_level = wr_reg - rd_reg;
  assign o_in_ready = (o_level < (AW+1)'(DEPTH));
  assign o_out_valid = valid_reg;
  assign o_out_data = data_reg;

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      valid_reg <= 1'b0;
      data_reg <= '0;
    end else if (i_ce) begin
      if (i_clr) begin
        wr_reg <= '0;
        rd_reg <= '0;
        valid_reg <= 1'b0;
      end else begin
        wr_reg <= wr_reg + (AW+1)'(push);
        rd_reg <= rd_reg + (AW+1)'(pop);
        if (pop) begin
          data_reg <= mem[rd_reg[AW-1:0]];
        end
        valid_reg <= pop | (valid_reg & ~i_out_ready);
      end
    end
  end
endmodule // tpu_fifo

// ===== verilog/tpu_dev.sv
// Purpose: device end of the packet user port
// Assumes: rx queues drop a beat on the edge after its pop pulse
// Notes: tx words go through a small fifo to the link side
// Operation
// - credit outputs follow selected information type
// - selector codes pick six credit views
// - link up low only in active state
// - window hits per beat, pairs both
// - rx beat moves when both readies low
// - sof on first, eof on last beat
// - poison held from first poisoned beat to packet end
// - without np ok, others pass np
// - user drops np ok one cycle early
// - rx remainder: high means upper half only
// - abort rx packet when link enters reset
// - report free tx buffers, up to 32
// - request internal send, wait for grant
// - user grants internal send, may hold grant
// - tx beat moves when both readies low
// - drop bad length or gapped streamed packets
// - user may poison any beat sof..eof
// - tx remainder counts on eof only
// - user aborts tx packet with abort
// - streamed packets have no gaps
// - user reset low while block in reset
// - system reset or no lock resets block
`timescale 1ns/100ps
module tpu_dev import tpu_pkg::*; #(
  parameter int FIFO_DEPTH = 4,
  parameter int MAX_PAYLOAD_DW = 32,
  parameter int INT_BEATS = 2,
  parameter logic [2:0] PAIR64 = 3'h0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  tpu_if.dev bus,
  input wire logic i_system_reset_n,
  input wire logic i_pll_lock,
  input wire logic i_phy_link_up,
  input wire logic i_link_reset,
  input wire logic i_dl_init_done,
  input wire logic [7:0][2:0][CD_W-1:0] i_fc_data,
  input wire logic [7:0][2:0][CH_W-1:0] i_fc_hdr,
  input wire logic [1:0] i_q_valid,
  input wire logic [1:0][DATA_W-1:0] i_q_beat,
  input wire logic [1:0] i_q_sof,
  input wire logic [1:0] i_q_eof,
  input wire logic [1:0] i_q_rem,
  input wire logic [1:0] i_q_poison,
  input wire logic [1:0][HIT_W-1:0] i_q_hit,
  output logic [1:0] o_q_pop,
  input wire logic i_int_pending,
  output logic o_int_start,
  output logic o_link_tx_valid,
  input wire logic i_link_tx_ready,
  output logic [TXW_W-1:0] o_link_tx_word,
  input wire logic i_buf_release
);
  localparam int MAX_BEATS = (MAX_PAYLOAD_DW + 5) / 2;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  // ****************************************************************
  // reset and input synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic in_reset_reg;
  wire logic [SYNC_W-1:0] async_in =
    {i_link_reset, i_phy_link_up, i_pll_lock, i_system_reset_n};
  wire logic [SYNC_W-1:0] agree = ~(s2_reg ^ s3_reg);
  wire logic clr = in_reset_reg;
  wire logic lrst = filt_reg[S_LRST];

  always_ff @(posedge i_clk or posedge i_rst or negedge i_system_reset_n)
  begin
    if (i_rst || !i_system_reset_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      in_reset_reg <= 1'b1;
    end else if (i_ce) begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (agree & s3_reg) | (~agree & filt_reg);
      in_reset_reg <= ~(filt_reg[S_SYS] & filt_reg[S_LOCK]);
    end
  end

  // ****************************************************************
  // link state and credits
  // ****************************************************************
  tpu_dl_type dl_reg, dl_next;
  wire logic sel_ok = (bus.credit_info_select != 3'h3) &&
    (bus.credit_info_select != 3'h7);
  wire logic [2:0][CD_W-1:0] cd_sel =
    sel_ok ? i_fc_data[bus.credit_info_select] : '0;
  wire logic [2:0][CH_W-1:0] ch_sel =
    sel_ok ? i_fc_hdr[bus.credit_info_select] : '0;

  always_comb begin
    dl_next = dl_reg;
    unique case (dl_reg)
      DL_INACTIVE: if (filt_reg[S_PHY]) dl_next = DL_INIT;
      DL_INIT: if (i_dl_init_done) dl_next = DL_ACTIVE;
      DL_ACTIVE: dl_next = DL_ACTIVE;
    endcase
    if (!filt_reg[S_PHY]) dl_next = DL_INACTIVE;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dl_reg <= DL_INACTIVE;
      bus.link_up_n <= 1'b1;
      bus.user_if_reset_n <= 1'b0;
      {bus.cpl_data_credits, bus.np_data_credits} <= '0;
      bus.posted_data_credits <= '0;
      {bus.cpl_hdr_credits, bus.np_hdr_credits} <= '0;
      bus.posted_hdr_credits <= '0;
    end else if (i_ce) begin
      dl_reg <= clr ? DL_INACTIVE : dl_next;
      bus.link_up_n <= clr | (dl_next != DL_ACTIVE);
      bus.user_if_reset_n <= ~clr;
      bus.cpl_data_credits <= cd_sel[0];
      bus.np_data_credits <= cd_sel[1];
      bus.posted_data_credits <= cd_sel[2];
      bus.cpl_hdr_credits <= ch_sel[0];
      bus.np_hdr_credits <= ch_sel[1];
      bus.posted_hdr_credits <= ch_sel[2];
    end
  end

  // ****************************************************************
  // receive path
  // ****************************************************************
  logic rx_in_pkt_reg, rx_from_np_reg, rx_poison_reg;
  logic [HIT_W-1:0] hit_x;
  wire logic rx_empty = bus.rx_src_ready_n;
  wire logic rx_accept = ~bus.rx_src_ready_n & ~bus.rx_dst_ready_n;
  wire logic np_ok = ~bus.rx_nonposted_ok_n;
  wire logic take_pc = rx_in_pkt_reg ? (~rx_from_np_reg & i_q_valid[0])
    : i_q_valid[0];
  wire logic take_np = rx_in_pkt_reg ? (rx_from_np_reg & i_q_valid[1])
    : (~i_q_valid[0] & i_q_valid[1] & np_ok);
  wire logic qi = take_np;
  wire logic do_abort = rx_empty & lrst & rx_in_pkt_reg & ~clr;
  wire logic rx_load = rx_empty & ~lrst & ~clr & (take_pc | take_np);
  wire logic pkt_poison = i_q_poison[qi] | (~i_q_sof[qi] & rx_poison_reg);

  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_pair
      wire logic both = i_q_hit[qi][2*gp] | i_q_hit[qi][2*gp+1];
      assign hit_x[2*gp] = PAIR64[gp] ? both : i_q_hit[qi][2*gp];
      assign hit_x[2*gp+1] = PAIR64[gp] ? both : i_q_hit[qi][2*gp+1];
    end
  endgenerate
  assign hit_x[6] = i_q_hit[qi][6];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {rx_in_pkt_reg, rx_from_np_reg, rx_poison_reg} <= '0;
      o_q_pop <= '0;
      bus.rx_src_ready_n <= 1'b1;
      {bus.rx_sof_n, bus.rx_eof_n, bus.rx_abort_n} <= 3'h7;
      {bus.rx_remainder_n, bus.rx_poisoned_n} <= 2'h3;
      bus.rx_beat <= '0;
      bus.rx_window_hit_n <= '1;
    end else if (i_ce) begin
      o_q_pop <= {rx_load & take_np, rx_load & take_pc};
      if (clr) begin
        rx_in_pkt_reg <= 1'b0;
        bus.rx_src_ready_n <= 1'b1;
      end else if (do_abort) begin
        rx_in_pkt_reg <= 1'b0;
        bus.rx_src_ready_n <= 1'b0;
        bus.rx_abort_n <= 1'b0;
        bus.rx_eof_n <= 1'b1;
        bus.rx_sof_n <= 1'b1;
      end else if (rx_load) begin
        rx_in_pkt_reg <= ~i_q_eof[qi];
        rx_from_np_reg <= take_np;
        rx_poison_reg <= pkt_poison;
        bus.rx_src_ready_n <= 1'b0;
        bus.rx_beat <= i_q_beat[qi];
        bus.rx_sof_n <= ~i_q_sof[qi];
        bus.rx_eof_n <= ~i_q_eof[qi];
        bus.rx_remainder_n <= i_q_eof[qi] & i_q_rem[qi];
        bus.rx_poisoned_n <= ~pkt_poison;
        bus.rx_abort_n <= 1'b1;
        bus.rx_window_hit_n <= ~hit_x;
      end else if (rx_accept) begin
        bus.rx_src_ready_n <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // transmit path
  // ****************************************************************
  tpu_tx_type tx_reg, tx_next;
  logic [10:0] beats_reg, exp_dw_reg;
  logic [7:0] int_cnt_reg;
  logic stream_reg, gap_reg;
  logic [BUF_W-1:0] free_reg;
  logic [LW-1:0] level;
  logic fifo_in_ready;
  wire logic tx_accept = ~bus.tx_src_ready_n & ~bus.tx_dst_ready_n;
  wire logic t_sof = ~bus.tx_sof_n;
  wire logic t_end = ~bus.tx_eof_n | ~bus.tx_abort_n;
  wire logic [10:0] hdr_len = (bus.tx_beat[HDR_LEN_LSB +: 10] == 10'h000)
    ? HDR_LEN_ZERO : {1'b0, bus.tx_beat[HDR_LEN_LSB +: 10]};
  wire logic [10:0] exp_now = (bus.tx_beat[HDR_4DW_BIT] ? HDR_DW_4
    : HDR_DW_3) + (bus.tx_beat[HDR_DATA_BIT] ? hdr_len : 11'h000);
  wire logic [10:0] exp_dw = t_sof ? exp_now : exp_dw_reg;
  wire logic [10:0] beats_now = t_sof ? 11'h001 : beats_reg + 11'h001;
  wire logic [10:0] rcv_dw = {beats_now[9:0], 1'b0} -
    {10'h000, bus.tx_remainder_n};
  wire logic stream_now = t_sof ? ~bus.tx_streamed_n : stream_reg;
  wire logic gap = (tx_reg == TX_USER) & stream_reg & bus.tx_src_ready_n
    & ~bus.tx_dst_ready_n;
  wire logic drop_now = ~bus.tx_eof_n & (gap_reg | (rcv_dw != exp_dw) |
    (beats_now > 11'(MAX_BEATS)));
  wire logic go_int = (tx_reg == TX_IDLE) & ~tx_accept & i_int_pending &
    ~bus.tx_internal_grant_n & ~clr;
  wire logic int_done = (tx_reg == TX_INT) &&
    (int_cnt_reg == 8'(INT_BEATS - 1));
  wire logic fifo_pop = o_link_tx_valid & i_link_tx_ready;
  wire logic [LW-1:0] level_next = level + LW'(tx_accept) -
    LW'(fifo_pop & (level != '0));
  wire logic buf_take = tx_accept & t_end & ~drop_now & bus.tx_abort_n;
  wire logic buf_give = i_buf_release & (free_reg != TX_BUF_MAX);
  wire logic [TXW_W-1:0] tx_word = {drop_now, stream_now,
    ~bus.tx_abort_n, ~bus.tx_poison_n, bus.tx_remainder_n,
    ~bus.tx_eof_n, t_sof, bus.tx_beat};

  always_comb begin
    tx_next = tx_reg;
    unique case (tx_reg)
      TX_IDLE: begin
        if (go_int) tx_next = TX_INT;
        else if (tx_accept & t_sof & ~t_end) tx_next = TX_USER;
      end
      TX_USER: if (tx_accept & t_end) tx_next = TX_IDLE;
      TX_INT: if (int_done) tx_next = TX_IDLE;
    endcase
  end

  wire logic dst_next = (level_next < LW'(FIFO_DEPTH)) & ~clr &
    (tx_next != TX_INT) & (dl_next == DL_ACTIVE) &
    ~(tx_next == TX_IDLE & free_reg == '0);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_reg <= TX_IDLE;
      {beats_reg, exp_dw_reg} <= '0;
      {int_cnt_reg, stream_reg, gap_reg} <= '0;
      free_reg <= TX_BUF_MAX;
      o_int_start <= 1'b0;
      bus.tx_dst_ready_n <= 1'b1;
      bus.tx_dropped_n <= 1'b1;
      bus.tx_internal_request_n <= 1'b1;
      bus.tx_free_buffers <= TX_BUF_MAX;
    end else if (i_ce) begin
      tx_reg <= clr ? TX_IDLE : tx_next;
      int_cnt_reg <= (tx_reg == TX_INT) ? int_cnt_reg + 8'h01 : 8'h00;
      o_int_start <= go_int;
      bus.tx_internal_request_n <= ~(i_int_pending & ~go_int &
        (tx_reg != TX_INT));
      bus.tx_dst_ready_n <= ~dst_next;
      bus.tx_dropped_n <= ~(tx_accept & drop_now);
      if (tx_accept) begin
        beats_reg <= beats_now;
        exp_dw_reg <= exp_dw;
        stream_reg <= stream_now;
      end
      gap_reg <= ~clr & ~(tx_accept & t_end) &
        ((gap_reg & ~(tx_accept & t_sof)) | gap);
      free_reg <= clr ? TX_BUF_MAX
        : free_reg - BUF_W'(buf_take) + BUF_W'(buf_give);
      bus.tx_free_buffers <= clr ? TX_BUF_MAX
        : free_reg - BUF_W'(buf_take) + BUF_W'(buf_give);
    end
  end

  tpu_fifo #(.WIDTH(TXW_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_clr(clr),
    .i_in_valid(tx_accept),
    .o_in_ready(fifo_in_ready),
    .i_in_data(tx_word),
    .o_out_valid(o_link_tx_valid),
    .i_out_ready(i_link_tx_ready),
    .o_out_data(o_link_tx_word),
    .o_level(level)
  );
endmodule // tpu_dev

// ===== verilog/tpu_usr.sv
// Purpose: user end of the packet user port
// Assumes: app tx beats are taken one at a time by pulse
// Notes: user state is cleared while the device holds user reset
`timescale 1ns/100ps
module tpu_usr import tpu_pkg::*; #(
  parameter int NP_W = 4,
  parameter bit GRANT_ALWAYS = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  tpu_if.usr bus,
  input wire logic [SEL_W-1:0] i_app_credit_select,
  input wire logic [NP_W-1:0] i_np_room,
  input wire logic i_hold_internal,
  input wire logic i_app_rx_ready,
  input wire logic i_app_tx_valid,
  input wire logic [DATA_W-1:0] i_app_tx_beat,
  input wire logic i_app_tx_sof,
  input wire logic i_app_tx_eof,
  input wire logic i_app_tx_rem,
  input wire logic i_app_tx_poison,
  input wire logic i_app_tx_abort,
  input wire logic i_app_tx_streamed,
  output logic o_app_tx_taken,
  output logic o_app_rx_valid,
  output logic [DATA_W-1:0] o_app_rx_beat,
  output logic [4:0] o_app_rx_flags,
  output logic [HIT_W-1:0] o_app_rx_hit,
  output logic o_app_link_up,
  output logic o_app_dropped
);
  // ****************************************************************
  // handshake decode
  // ****************************************************************
  logic in_pkt_reg;
  wire logic clr = ~bus.user_if_reset_n;
  wire logic rx_accept = ~bus.rx_src_ready_n & ~bus.rx_dst_ready_n;
  wire logic tx_accept = ~bus.tx_src_ready_n & ~bus.tx_dst_ready_n;
  wire logic tx_empty = bus.tx_src_ready_n;
  wire logic tx_load = (tx_empty | tx_accept) & i_app_tx_valid & ~clr;
  wire logic may_poison = i_app_tx_sof | in_pkt_reg;
  wire logic np_stop = (i_np_room <= NP_W'(1));
  wire logic grant = GRANT_ALWAYS |
    (~bus.tx_internal_request_n & ~i_hold_internal);

  // ****************************************************************
  // transmit stage and control outputs
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      in_pkt_reg <= 1'b0;
      o_app_tx_taken <= 1'b0;
      bus.tx_src_ready_n <= 1'b1;
      bus.tx_beat <= '0;
      {bus.tx_sof_n, bus.tx_eof_n, bus.tx_remainder_n} <= 3'h7;
      {bus.tx_poison_n, bus.tx_abort_n, bus.tx_streamed_n} <= 3'h7;
      bus.credit_info_select <= SEL_RX_SPACE;
      bus.rx_nonposted_ok_n <= 1'b1;
      bus.tx_internal_grant_n <= 1'b1;
    end else if (i_ce) begin
      o_app_tx_taken <= tx_load;
      bus.credit_info_select <= i_app_credit_select;
      bus.rx_nonposted_ok_n <= clr | np_stop;
      bus.tx_internal_grant_n <= clr | ~grant;
      if (clr) begin
        in_pkt_reg <= 1'b0;
        bus.tx_src_ready_n <= 1'b1;
      end else if (tx_load) begin
        in_pkt_reg <= ~(i_app_tx_eof | i_app_tx_abort) &
          (i_app_tx_sof | in_pkt_reg);
        bus.tx_src_ready_n <= 1'b0;
        bus.tx_beat <= i_app_tx_beat;
        bus.tx_sof_n <= ~i_app_tx_sof;
        bus.tx_eof_n <= ~i_app_tx_eof;
        bus.tx_remainder_n <= i_app_tx_eof & i_app_tx_rem;
        bus.tx_poison_n <= ~(i_app_tx_poison & may_poison);
        bus.tx_abort_n <= ~i_app_tx_abort;
        bus.tx_streamed_n <= ~i_app_tx_streamed;
      end else if (tx_accept) begin
        bus.tx_src_ready_n <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // receive capture
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.rx_dst_ready_n <= 1'b1;
      o_app_rx_valid <= 1'b0;
      o_app_rx_beat <= '0;
      o_app_rx_flags <= '0;
      o_app_rx_hit <= '0;
      o_app_link_up <= 1'b0;
      o_app_dropped <= 1'b0;
    end else if (i_ce) begin
      bus.rx_dst_ready_n <= clr | ~i_app_rx_ready;
      o_app_rx_valid <= rx_accept & ~clr;
      o_app_link_up <= ~bus.link_up_n;
      o_app_dropped <= ~bus.tx_dropped_n;
      if (rx_accept) begin
        o_app_rx_beat <= bus.rx_beat;
        o_app_rx_flags <= {~bus.rx_abort_n, ~bus.rx_poisoned_n,
          ~bus.rx_eof_n & bus.rx_remainder_n, ~bus.rx_eof_n,
          ~bus.rx_sof_n};
        o_app_rx_hit <= ~bus.rx_window_hit_n;
      end
    end
  end
endmodule // tpu_usr

// ===== test/tpu_checker.sv
// Purpose: port checks of the packet user port
// Assumes: one clock, reset async high
// Notes: sees interface signals only
`timescale 1ns/100ps
module tpu_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [63:0] rx_beat,
  input wire logic rx_src_ready_n,
  input wire logic rx_dst_ready_n,
  input wire logic rx_sof_n,
  input wire logic rx_eof_n,
  input wire logic rx_abort_n,
  input wire logic link_up_n,
  input wire logic tx_dst_ready_n,
  input wire logic tx_dropped_n,
  input wire logic [5:0] tx_free_buffers,
  input wire logic user_if_reset_n,
  input wire logic tx_internal_request_n,
  input wire logic tx_internal_grant_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire rx_acc = !rx_src_ready_n && !rx_dst_ready_n;
  chk_rx_hold: assert property (!rx_src_ready_n && rx_dst_ready_n |=>
    !rx_src_ready_n && $stable(rx_beat)) else $error("rx beat moved");
  chk_rx_space: assert property (rx_acc |=> rx_src_ready_n)
    else $error("rx beat too soon");
  chk_abort_flags: assert property (!rx_abort_n && !rx_src_ready_n |->
    rx_sof_n && rx_eof_n) else $error("abort beat framed");
  chk_buf_max: assert property (tx_free_buffers <= 6'h20)
    else $error("too many buffers");
  chk_drop_pulse: assert property (!tx_dropped_n |=> tx_dropped_n)
    else $error("drop too long");
  chk_dst_link: assert property (link_up_n && $past(link_up_n) |->
    tx_dst_ready_n) else $error("tx ready without link");
  chk_rst_quiet: assert property (!user_if_reset_n |->
    link_up_n && rx_src_ready_n) else $error("active in reset");
  chk_req_wait: assert property (!tx_internal_request_n &&
    tx_internal_grant_n |=> !tx_internal_request_n) else $error("no grant");
  cover property (rx_acc && !rx_eof_n);
  cover property (!tx_dropped_n);
  cover property (!tx_internal_request_n && !tx_internal_grant_n);
endmodule // tpu_checker

// ===== test/transaction_packet_user_port_tb.sv
// Purpose: bench of both port ends joined
// Assumes: 100 MHz clock, reset 8 cycles
// Notes: credit codes walk as table rows
`timescale 1ns/100ps
module transaction_packet_user_port_tb;
  import tpu_pkg::*;
  logic i_clk = 0, i_rst = 1, srn = 0, plu = 0, hold = 0, intp = 0;
  logic lck = 1, lrs = 0, brel = 0, rdy = 1, pz = 0, ab = 0, st = 0;
  logic [3:0] room = 4'hF;
  logic [7:0][2:0][CD_W-1:0] fcd = '0;
  logic [1:0] qv = 0, qs = 0, qe = 0, qp = 0, pop;
  logic [1:0][DATA_W-1:0] qb = '0;
  logic [SEL_W-1:0] sel = 0;
  logic tv = 0, ts = 0, te = 0, tr = 0, taken, rxv, drop, dseen = 0;
  logic [DATA_W-1:0] tx_d = '0, rxb;
  logic [4:0] rxf;
  logic [HIT_W-1:0] rxh;
  logic [11:0] exp_c [8] = '{12'h0, 12'h10, 12'h20, 12'h0, 12'h40,
    12'h50, 12'h60, 12'h0};
  int bad_count = 0, total_checks = 0, k, j;
  tpu_if bus ();
  tpu_dev u_tpu_dev (.i_clk, .i_rst, .i_ce(1'b1), .bus,
    .i_system_reset_n(srn), .i_pll_lock(lck), .i_phy_link_up(plu),
    .i_link_reset(lrs), .i_dl_init_done(plu), .i_fc_data(fcd),
    .i_fc_hdr('0), .i_q_valid(qv), .i_q_beat(qb), .i_q_sof(qs),
    .i_q_eof(qe), .i_q_rem(qe), .i_q_poison(qp), .i_q_hit({2{7'h04}}),
    .o_q_pop(pop), .i_int_pending(intp), .o_int_start(),
    .o_link_tx_valid(), .i_link_tx_ready(1'b1), .o_link_tx_word(),
    .i_buf_release(brel));
  tpu_usr u_tpu_usr (.i_clk, .i_rst, .i_ce(1'b1), .bus,
    .i_app_credit_select(sel), .i_np_room(room), .i_hold_internal(hold),
    .i_app_rx_ready(rdy), .i_app_tx_valid(tv), .i_app_tx_beat(tx_d),
    .i_app_tx_sof(ts), .i_app_tx_eof(te), .i_app_tx_rem(tr),
    .i_app_tx_poison(pz), .i_app_tx_abort(ab),
    .i_app_tx_streamed(st), .o_app_tx_taken(taken),
    .o_app_rx_valid(rxv), .o_app_rx_beat(rxb), .o_app_rx_flags(rxf),
    .o_app_rx_hit(rxh), .o_app_link_up(), .o_app_dropped(drop));
  tpu_checker u_tpu_checker (.i_clk, .i_rst, .rx_beat(bus.rx_beat),
    .rx_src_ready_n(bus.rx_src_ready_n), .rx_sof_n(bus.rx_sof_n),
    .rx_dst_ready_n(bus.rx_dst_ready_n), .rx_eof_n(bus.rx_eof_n),
    .rx_abort_n(bus.rx_abort_n), .link_up_n(bus.link_up_n),
    .tx_dst_ready_n(bus.tx_dst_ready_n), .tx_dropped_n(bus.tx_dropped_n),
    .tx_free_buffers(bus.tx_free_buffers),
    .user_if_reset_n(bus.user_if_reset_n),
    .tx_internal_request_n(bus.tx_internal_request_n),
    .tx_internal_grant_n(bus.tx_internal_grant_n));
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (drop === 1'b1) dseen <= 1'b1;
  task automatic ck(string n, logic [63:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bnd(int n);
    if (n >= 99) begin
      bad_count++;
      finish_test;
    end
  endtask
  task automatic snd(logic [63:0] d, logic s, e, r);
    tx_d <= d;
    {ts, te, tr, tv} <= {s, e, r, 1'b1};
    @(posedge i_clk);
    tv <= 1'b0;
    for (k = 0; k < 99 && taken !== 1'b1; k++) @(posedge i_clk);
    bnd(k);
    repeat (2) @(posedge i_clk);
  endtask
  task automatic rcv(logic [63:0] d, logic s, e);
    qb[0] <= d;
    {qv[0], qs[0], qe[0], qp[0]} <= {1'b1, s, e, s};
    for (k = 0; k < 99 && pop[0] !== 1'b1; k++) @(posedge i_clk);
    bnd(k);
    qv[0] <= 1'b0;
    for (k = 0; k < 99 && rxv !== 1'b1; k++) @(posedge i_clk);
    bnd(k);
    ck("rx beat", rxb, d);
    ck("rx flags", rxf, {2'b01, e, e, s});
    ck("rx hits", rxh, 7'h04);
  endtask
  initial begin
    for (j = 0; j < 8; j++) fcd[j][0] = CD_W'(16 * j);
    repeat (8) @(posedge i_clk);
    ck("free bufs", bus.tx_free_buffers, 6'h20);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    ck("usr reset", bus.user_if_reset_n, 1'b0);
    {srn, plu} <= 2'b11;
    for (k = 0; k < 99 && bus.tx_dst_ready_n !== 1'b0; k++) @(posedge i_clk);
    bnd(k);
    ck("link up", bus.link_up_n, 1'b0);
    for (j = 0; j < 8; j++) begin
      sel <= SEL_W'(j);
      repeat (3) @(posedge i_clk);
      ck("credits", bus.cpl_data_credits, exp_c[j]);
    end
    rcv(64'h0123456789ABCDEF, 1'b1, 1'b0);
    rcv(64'hFEDCBA9876543210, 1'b0, 1'b1);
    snd(64'h0, 1'b1, 1'b0, 1'b0);
    snd(64'h5, 1'b0, 1'b1, 1'b1);
    repeat (6) @(posedge i_clk);
    ck("good bufs", bus.tx_free_buffers, 6'h1F);
    ck("no drop", dseen, 1'b0);
    snd(64'h0, 1'b1, 1'b1, 1'b0);
    repeat (4) @(posedge i_clk);
    ck("drop", dseen, 1'b1);
    ck("bad bufs", bus.tx_free_buffers, 6'h1F);
    brel <= 1'b1;
    @(posedge i_clk);
    brel <= 1'b0;
    rcv(64'h7, 1'b1, 1'b0);
    {lrs, rdy} <= 2'b10;
    repeat (9) @(posedge i_clk);
    rdy <= 1'b1;
    repeat (4) @(posedge i_clk);
    ck("freed", bus.tx_free_buffers, 6'h20);
    ck("abort", rxf, 5'h18);
    lrs <= 1'b0;
    {hold, intp} <= 2'b11;
    repeat (8) @(posedge i_clk);
    ck("int req", bus.tx_internal_request_n, 1'b0);
    hold <= 1'b0;
    for (k = 0; k < 99 && bus.tx_internal_request_n !== 1'b1; k++)
      @(posedge i_clk);
    intp <= 1'b0;
    bnd(k);
    lck <= 1'b0;
    repeat (8) @(posedge i_clk);
    ck("lock lost", bus.user_if_reset_n, 1'b0);
    finish_test;
  end
endmodule // transaction_packet_user_port_tb
